/* flash_ctrl_pkg.sv */
// Shared constants and carrier types for the flash access and program/erase controller.
// Assumes a single system clock of 100 MHz and four flash modules.
package flash_ctrl_pkg;
    localparam int NUM_MODULES = 4;
    localparam int MOD_W = 2;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;

    // Wait-state count; reset value is the largest that any clock rate needs.
    localparam int WS_W = 3;
    localparam logic [WS_W-1:0] WS_MIN = 3'h1;
    localparam logic [WS_W-1:0] WS_RESET = 3'h4;

    // Parallel program/erase limits depending on read activity.
    localparam int SYS_CLK_MHZ = 100;
    localparam int PAR_PE_MAX_MHZ = 80;
    localparam int PAR_PE_LIMIT = 4;
    localparam int SERIAL_PE_LIMIT = 1;
    localparam logic [MOD_W-1:0] SHARED_READ_MODULE = 2'h3;

    // Program and erase times, counted in ticks of the internal flash clock.
    localparam int FLASH_TICK_NS = 1000;
    localparam int ERASE_TYP_US = 7000;
    localparam int ERASE_MAX_US = 8000;
    localparam int PROG_TYP_US = 3000;
    localparam int PROG_MAX_US = 3500;
    localparam int ERASE_TICKS = ERASE_TYP_US * 1000 / FLASH_TICK_NS;
    localparam int ERASE_MAX_TICKS = ERASE_MAX_US * 1000 / FLASH_TICK_NS;
    localparam int PROG_TICKS = PROG_TYP_US * 1000 / FLASH_TICK_NS;
    localparam int PROG_MAX_TICKS = PROG_MAX_US * 1000 / FLASH_TICK_NS;
    localparam int TICK_W = 16;

    typedef enum logic [1:0] {FETCH_IDLE, FETCH_DEMAND, FETCH_AHEAD} fetch_e;

    typedef struct packed {
        logic req;
        logic erase;
        logic [MOD_W-1:0] target;
    } pe_cmd_s;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } rd_ans_s;
endpackage

/* pe_timer.sv */
// One program/erase timer for a single flash module.
// Assumes flashTick is a one-cycle pulse per internal flash clock period.
`timescale 1ns/1ps
`default_nettype none
module pe_timer #(
    parameter int ERASE_TICKS = flash_ctrl_pkg::ERASE_TICKS,
    parameter int PROG_TICKS = flash_ctrl_pkg::PROG_TICKS
) (
    input wire logic clk, // system clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic start, // one-cycle start pulse
    input wire logic erase, // 1 erase, 0 program, taken with start
    input wire logic flashTick, // internal flash clock tick
    output logic busy, // operation running
    output logic isErase, // running operation is an erase
    output logic done // one-cycle completion pulse
);
    typedef struct packed {
        logic busy;
        logic erase;
        logic done;
        logic [flash_ctrl_pkg::TICK_W-1:0] cnt;
    } timer_s;

    timer_s s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (s_q.busy) begin
            if (flashTick) begin
                if (s_q.cnt == 16'h0001) begin
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                end
                s_d.cnt = s_q.cnt - 16'h0001;
            end
        end else if (start) begin
            // Duration comes from the flash clock; the extra start cycle is the sequencer overhead.
            s_d.busy = 1'b1;
            s_d.erase = erase;
            s_d.cnt = erase ? ERASE_TICKS[flash_ctrl_pkg::TICK_W-1:0] : PROG_TICKS[flash_ctrl_pkg::TICK_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign isErase = s_q.erase;
    assign done = s_q.done;

    erase_bound_a: assert property (@(posedge clk) disable iff (!nrst)
        s_q.busy && s_q.erase |-> s_q.cnt <= flash_ctrl_pkg::ERASE_MAX_TICKS)
        else $error("Erase count beyond its longest time.");

    prog_bound_a: assert property (@(posedge clk) disable iff (!nrst)
        s_q.busy && !s_q.erase |-> s_q.cnt <= flash_ctrl_pkg::PROG_MAX_TICKS)
        else $error("Program count beyond its longest time.");
endmodule
`default_nettype wire

/* flash_access_and_program_control.sv */
// Flash read path with wait states and prefetch, plus program/erase admission and timing.
// Assumes core requests, read masks and flash data are synchronous to clk; flash data is valid
// on the last wait-state cycle of a read.
// How it works
// - After reset every sector reads as blank and no protection is active.
// - Full wait states are spent only on non-sequential reads; sequential ones wait only for what is left of their prefetch.
// - The next word is fetched ahead so sequential reads outrun random ones.
// - Up to 4 modules program/erase at once when at most one is read, clock <= 80 MHz.
// - With several modules read only module 3 may program/erase, if it is not read itself and no other module is busy.
// - A sector erase completes within 8.0 ms, typically 7 ms.
// - A page program completes within 3.5 ms, typically 3 ms.
// - Program/erase durations count internal flash clock ticks plus small overhead.
// - All read sequencing runs on the system clock, so waits scale with its period.
`timescale 1ns/1ps
`default_nettype none
module flash_access_and_program_control #(
    parameter int ERASE_TICKS = flash_ctrl_pkg::ERASE_TICKS,
    parameter int PROG_TICKS = flash_ctrl_pkg::PROG_TICKS
) (
    input wire logic clk, // system clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic wsLoad, // pulse: load a new wait-state count
    input wire logic [flash_ctrl_pkg::WS_W-1:0] wsValue, // wait-state count to load
    output logic [flash_ctrl_pkg::WS_W-1:0] waitStateCount, // current wait-state count
    input wire logic rdReq, // core read request
    input wire logic [flash_ctrl_pkg::ADDR_W-1:0] rdAddr, // core word address
    output logic rdReady, // request taken when rdReq and rdReady
    output flash_ctrl_pkg::rd_ans_s rdAns, // answer pulse with data
    output logic flashRdEn, // flash array read in progress
    output logic [flash_ctrl_pkg::ADDR_W-1:0] flashRdAddr, // flash array word address
    input wire logic [flash_ctrl_pkg::DATA_W-1:0] flashRdData, // flash array read data
    input wire logic [flash_ctrl_pkg::NUM_MODULES-1:0] readMask, // modules the core executes from
    input wire flash_ctrl_pkg::pe_cmd_s peCmd, // program/erase command
    output logic peAccept, // pulse: command started
    output logic peReject, // pulse: command refused
    input wire logic flashTick, // internal flash clock tick
    output logic [flash_ctrl_pkg::NUM_MODULES-1:0] peBusy, // module program/erase active
    output logic [flash_ctrl_pkg::NUM_MODULES-1:0] peErase, // active operation is erase
    output logic [flash_ctrl_pkg::NUM_MODULES-1:0] peDone, // pulse: operation finished
    output logic [flash_ctrl_pkg::NUM_MODULES-1:0] moduleBlank, // module holds no programmed data
    output logic protectActive // flash protection installed
);
    typedef struct packed {
        logic [flash_ctrl_pkg::WS_W-1:0] ws;
        flash_ctrl_pkg::fetch_e fetch;
        logic [flash_ctrl_pkg::ADDR_W-1:0] fetchAddr;
        logic [flash_ctrl_pkg::WS_W-1:0] fetchCnt;
        logic bufValid;
        logic [flash_ctrl_pkg::ADDR_W-1:0] bufAddr;
        logic [flash_ctrl_pkg::DATA_W-1:0] bufData;
        logic pendValid;
        logic [flash_ctrl_pkg::ADDR_W-1:0] pendAddr;
        flash_ctrl_pkg::rd_ans_s ans;
        logic accept;
        logic reject;
        logic [flash_ctrl_pkg::NUM_MODULES-1:0] blank;
    } ctrl_s;

    localparam logic [flash_ctrl_pkg::ADDR_W-1:0] ADDR_ONE = 24'h000001;
    localparam logic [flash_ctrl_pkg::WS_W-1:0] CNT_ONE = 3'h1;

    ctrl_s s_q, s_d;
    logic [flash_ctrl_pkg::NUM_MODULES-1:0] peStart;
    logic [flash_ctrl_pkg::NUM_MODULES-1:0] timerDone;
    logic [2:0] readCnt;
    logic [2:0] busyCnt;
    logic [2:0] peLimit;
    logic peOk;
    logic hit;
    logic fetchStart;

    // Read-activity and program/erase admission.
    always_comb begin
        readCnt = 3'h0;
        busyCnt = 3'h0;
        for (int i = 0; i < flash_ctrl_pkg::NUM_MODULES; i++) begin
            readCnt = readCnt + {2'h0, readMask[i]};
            busyCnt = busyCnt + {2'h0, peBusy[i]};
        end
        // At 100 MHz the parallel allowance is out of reach, so operations run one at a time.
        if (readCnt <= 3'h1 && flash_ctrl_pkg::SYS_CLK_MHZ <= flash_ctrl_pkg::PAR_PE_MAX_MHZ) begin
            peLimit = 3'(flash_ctrl_pkg::PAR_PE_LIMIT);
        end else begin
            peLimit = 3'(flash_ctrl_pkg::SERIAL_PE_LIMIT);
        end
        peOk = !peBusy[peCmd.target] && !readMask[peCmd.target]
            && (busyCnt < peLimit)
            && (readCnt <= 3'h1 || peCmd.target == flash_ctrl_pkg::SHARED_READ_MODULE);
        peStart = '0;
        if (peCmd.req && peOk) begin
            peStart[peCmd.target] = 1'b1;
        end
    end

    assign hit = s_q.pendValid && s_q.bufValid && (s_q.bufAddr == s_q.pendAddr);

    always_comb begin
        s_d = s_q;
        s_d.ans.valid = 1'b0;
        s_d.accept = peCmd.req && peOk;
        s_d.reject = peCmd.req && !peOk;
        fetchStart = 1'b0;
        if (wsLoad) begin
            s_d.ws = (wsValue < flash_ctrl_pkg::WS_MIN) ? flash_ctrl_pkg::WS_MIN : wsValue;
        end
        for (int i = 0; i < flash_ctrl_pkg::NUM_MODULES; i++) begin
            // A program starting in the cycle the previous operation ends is the newer event and wins.
            if (peStart[i] && !peCmd.erase) begin
                s_d.blank[i] = 1'b0;
            end else if (timerDone[i]) begin
                s_d.blank[i] = peErase[i];
            end
        end
        // Fetch engine: one word per wait-state window, clocked by the system clock.
        if (s_q.fetch != flash_ctrl_pkg::FETCH_IDLE) begin
            if (s_q.fetchCnt == CNT_ONE) begin
                s_d.fetch = flash_ctrl_pkg::FETCH_IDLE;
                s_d.bufValid = 1'b1;
                s_d.bufAddr = s_q.fetchAddr;
                s_d.bufData = flashRdData;
            end else begin
                s_d.fetchCnt = s_q.fetchCnt - CNT_ONE;
            end
        end
        if (hit) begin
            s_d.ans.valid = 1'b1;
            s_d.ans.data = s_q.bufData;
            s_d.pendValid = 1'b0;
            if (s_d.fetch == flash_ctrl_pkg::FETCH_IDLE) begin
                s_d.fetch = flash_ctrl_pkg::FETCH_AHEAD;
                s_d.fetchAddr = s_q.pendAddr + ADDR_ONE;
                s_d.fetchCnt = s_q.ws;
                fetchStart = 1'b1;
            end
        end else if (s_q.pendValid) begin
            // A fetch already under way for this word only costs its remaining cycles.
            if (s_q.fetch == flash_ctrl_pkg::FETCH_IDLE || s_q.fetchAddr != s_q.pendAddr) begin
                s_d.fetch = flash_ctrl_pkg::FETCH_DEMAND;
                s_d.fetchAddr = s_q.pendAddr;
                s_d.fetchCnt = s_q.ws;
                fetchStart = 1'b1;
            end
        end
        if (!s_q.pendValid && rdReq) begin
            s_d.pendValid = 1'b1;
            s_d.pendAddr = rdAddr;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.ws <= flash_ctrl_pkg::WS_RESET;
            s_q.fetch <= flash_ctrl_pkg::FETCH_IDLE;
            s_q.blank <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    genvar m;
    generate
        for (m = 0; m < flash_ctrl_pkg::NUM_MODULES; m++) begin : gModule
            pe_timer #(
                .ERASE_TICKS(ERASE_TICKS),
                .PROG_TICKS(PROG_TICKS)
            ) uTimer (
                .clk(clk),
                .nrst(nrst),
                .start(peStart[m]),
                .erase(peCmd.erase),
                .flashTick(flashTick),
                .busy(peBusy[m]),
                .isErase(peErase[m]),
                .done(timerDone[m])
            );
        end
    endgenerate

    assign peDone = timerDone;
    assign waitStateCount = s_q.ws;
    assign rdReady = !s_q.pendValid;
    assign rdAns = s_q.ans;
    assign flashRdEn = (s_q.fetch != flash_ctrl_pkg::FETCH_IDLE);
    assign flashRdAddr = s_q.fetchAddr;
    assign peAccept = s_q.accept;
    assign peReject = s_q.reject;
    assign moduleBlank = s_q.blank;
    assign protectActive = 1'b0;

    ws_reset_a: assert property (@(posedge clk)
        $rose(nrst) |-> waitStateCount == 3'h4)
        else $error("Wait states not at largest value after reset.");

    blank_reset_a: assert property (@(posedge clk)
        $rose(nrst) |-> moduleBlank == 4'hF && !protectActive)
        else $error("Flash not blank and unprotected after reset.");

    fetch_len_a: assert property (@(posedge clk) disable iff (!nrst)
        fetchStart |=> flashRdEn && s_q.fetchCnt == $past(s_q.ws))
        else $error("Fetch window differs from wait-state count.");

    seq_hit_a: assert property (@(posedge clk) disable iff (!nrst)
        hit |=> rdAns.valid && rdAns.data == $past(s_q.bufData))
        else $error("Buffered word not answered next cycle.");

    prefetch_next_a: assert property (@(posedge clk) disable iff (!nrst)
        hit && s_q.fetch == flash_ctrl_pkg::FETCH_IDLE
        |=> flashRdEn && flashRdAddr == $past(s_q.pendAddr) + ADDR_ONE)
        else $error("No prefetch of the following word.");

    miss_wait_a: assert property (@(posedge clk) disable iff (!nrst)
        s_q.pendValid && !hit && s_q.fetch == flash_ctrl_pkg::FETCH_IDLE && s_q.ws == 3'h2
        |=> !rdAns.valid [*3] ##1 rdAns.valid)
        else $error("Miss answered outside its wait-state window.");

    pe_self_a: assert property (@(posedge clk) disable iff (!nrst)
        (peStart & readMask) == 4'h0)
        else $error("Program/erase started on a module being read.");

    pe_limit_a: assert property (@(posedge clk) disable iff (!nrst)
        busyCnt <= 3'h4 && (flash_ctrl_pkg::SYS_CLK_MHZ <= flash_ctrl_pkg::PAR_PE_MAX_MHZ || busyCnt <= 3'h1))
        else $error("Too many modules in program/erase.");

    pe_serial_a: assert property (@(posedge clk) disable iff (!nrst)
        readCnt > 3'h1 && busyCnt != 3'h0 |-> peStart == 4'h0)
        else $error("Second program/erase started during multi-module reads.");
endmodule
`default_nettype wire

/* flash_array_model.sv */
// Behavioural flash array seen by the read path: returns a word derived from the address.
// Assumes the controller samples data only while its array read window is open.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
    input wire logic clk, // system clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic flashRdEn, // array read window open
    input wire logic [flash_ctrl_pkg::ADDR_W-1:0] flashRdAddr, // array word address
    output logic [flash_ctrl_pkg::DATA_W-1:0] flashRdData // array word
);
    logic toggle_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            toggle_q <= 1'b0;
        end else begin
            toggle_q <= !toggle_q;
        end
    end

    // Outside a window the bus changes every cycle, so a late sample cannot pass by luck.
    assign flashRdData = flashRdEn ? {8'h5A, flashRdAddr} : (toggle_q ? 32'hA5C3_3C5A : 32'h5A3C_C3A5);
endmodule
`default_nettype wire

/* tb_flash_access_and_program_control.sv */
// Self-checking bench for the flash access and program/erase controller.
// Assumes the flash array model file and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_flash_access_and_program_control;
    localparam int ERASE_N = 5;
    localparam int PROG_N = 3;
    logic clk = 1'b0, nrst = 1'b0, wsLoad = 1'b0, rdReq = 1'b0, flashTick = 1'b0;
    logic rdReady, flashRdEn, peAccept, peReject, protectActive;
    logic [flash_ctrl_pkg::WS_W-1:0] wsValue = 3'h0;
    logic [flash_ctrl_pkg::WS_W-1:0] waitStateCount;
    logic [flash_ctrl_pkg::ADDR_W-1:0] rdAddr = 24'h000000;
    logic [flash_ctrl_pkg::ADDR_W-1:0] flashRdAddr;
    logic [flash_ctrl_pkg::DATA_W-1:0] flashRdData;
    logic [3:0] readMask = 4'h0;
    logic [3:0] peBusy, peErase, peDone, moduleBlank;
    flash_ctrl_pkg::rd_ans_s rdAns;
    flash_ctrl_pkg::pe_cmd_s peCmd = '0;
    int fails = 0, cmpCount = 0;

    always #5 clk = !clk;

    flash_access_and_program_control #(.ERASE_TICKS(ERASE_N), .PROG_TICKS(PROG_N)) i_dut (
        .clk(clk), .nrst(nrst), .wsLoad(wsLoad), .wsValue(wsValue), .waitStateCount(waitStateCount),
        .rdReq(rdReq), .rdAddr(rdAddr), .rdReady(rdReady), .rdAns(rdAns), .flashRdEn(flashRdEn),
        .flashRdAddr(flashRdAddr), .flashRdData(flashRdData), .readMask(readMask), .peCmd(peCmd),
        .peAccept(peAccept), .peReject(peReject), .flashTick(flashTick), .peBusy(peBusy),
        .peErase(peErase), .peDone(peDone), .moduleBlank(moduleBlank), .protectActive(protectActive));

    flash_array_model i_array (.clk(clk), .nrst(nrst), .flashRdEn(flashRdEn), .flashRdAddr(flashRdAddr),
        .flashRdData(flashRdData));

    task automatic final_report();
        if (fails == 0 && cmpCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic set_ws(input logic [2:0] v, input logic [2:0] expv);
        @(negedge clk) wsLoad = 1'b1;
        wsValue = v;
        @(negedge clk) wsLoad = 1'b0;
        `CHK(waitStateCount, expv)
    endtask

    // Latency counts edges from the taking edge to the edge that shows the answer.
    task automatic rd(input logic [23:0] a, output int lat);
        @(negedge clk) rdReq = 1'b1;
        rdAddr = a;
        `CHK(rdReady, 1'b1)
        @(negedge clk) rdReq = 1'b0;
        lat = 1;
        while (rdAns.valid !== 1'b1 && lat < 60) begin
            @(negedge clk);
            lat++;
        end
        if (lat >= 60) begin
            fails++;
            final_report();
        end
        `CHK(rdAns.data, {8'h5A, a})
    endtask

    task automatic pe(input logic er, input logic [1:0] m, input logic ok);
        logic a, r;
        @(negedge clk) peCmd = '{req: 1'b1, erase: er, target: m};
        @(negedge clk) peCmd = '0;
        a = peAccept;
        r = peReject;
        @(negedge clk) a = a | peAccept;
        r = r | peReject;
        `CHK({a, r}, {ok, !ok})
    endtask

    // Busy must hold through n-1 ticks and end within a few cycles of the n-th.
    task automatic run_pe(input logic [1:0] m, input int n);
        logic d;
        d = 1'b0;
        for (int i = 0; i < n; i++) begin
            `CHK(peBusy[m], 1'b1)
            @(negedge clk) flashTick = 1'b1;
            @(negedge clk) flashTick = 1'b0;
        end
        for (int k = 0; k < 4 && peBusy[m] !== 1'b0; k++) begin
            @(negedge clk);
            d = d | peDone[m];
        end
        d = d | peDone[m];
        `CHK({peBusy[m], d}, 2'b01)
    endtask

    task automatic t_reset();
        `CHK(waitStateCount, flash_ctrl_pkg::WS_RESET)
        `CHK({moduleBlank, protectActive, peBusy}, 9'h1E0)
    endtask

    task automatic t_wait_scaling();
        int l1, l4, l2;
        set_ws(3'h0, 3'h1);
        repeat (12) @(negedge clk);
        rd(24'h000100, l1);
        set_ws(3'h4, 3'h4);
        repeat (12) @(negedge clk);
        rd(24'h000200, l4);
        `CHK(l4 - l1, 3)
        `CHK(l1 > 2, 1'b1)
        set_ws(3'h2, 3'h2);
        repeat (12) @(negedge clk);
        rd(24'h000300, l2);
        `CHK(l2 - l1, 1)
    endtask

    task automatic t_sequential();
        int miss, hit, chain;
        set_ws(3'h3, 3'h3);
        repeat (12) @(negedge clk);
        rd(24'h0ABCDE, miss);
        repeat (12) @(negedge clk);
        rd(24'h0ABCDF, hit);
        `CHK(hit, 2)
        rd(24'h0ABCE0, chain);
        `CHK(chain <= miss, 1'b1)
    endtask

    task automatic t_prog_erase();
        readMask = 4'h0;
        pe(1'b1, 2'h0, 1'b1);
        pe(1'b0, 2'h1, 1'b0);
        run_pe(2'h0, ERASE_N);
        `CHK({moduleBlank[0], peErase[0]}, 2'b11)
        pe(1'b0, 2'h1, 1'b1);
        `CHK(moduleBlank[1], 1'b0)
        run_pe(2'h1, PROG_N);
        pe(1'b1, 2'h1, 1'b1);
        run_pe(2'h1, ERASE_N);
        @(negedge clk);
        `CHK({moduleBlank[1], peErase[1]}, 2'b11)
        readMask = 4'h4;
        pe(1'b1, 2'h2, 1'b0);
        readMask = 4'h3;
        pe(1'b1, 2'h2, 1'b0);
        pe(1'b0, 2'h3, 1'b1);
        pe(1'b0, 2'h2, 1'b0);
        run_pe(2'h3, PROG_N);
        `CHK(moduleBlank, 4'h7)
    endtask

    initial begin
        repeat (8) @(negedge clk);
        t_reset();
        nrst = 1'b1;
        t_wait_scaling();
        t_sequential();
        t_prog_erase();
        final_report();
    end
endmodule
`default_nettype wire
